/* hw/slc_global_config.sv */
module slc_global_config
    import slc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic frame_start,
    input wire logic frame_valid,
    input wire logic [13:0] frame_byte_count,
    input wire logic frame_has_tag,
    input wire logic frame_vid_invalid,
    input wire logic unknown_vid_fwd_en,
    input wire logic unknown_vid_fwd_host,
    input wire logic [47:0] dest_addr,
    input wire logic entry_update,
    input wire logic age_tick,
    input wire logic [2:0] entry_age_in,
    output logic frame_truncate,
    output logic [15:0] frame_tag_type,
    output logic vlan_mode,
    output logic frame_drop,
    output logic frame_to_host,
    output logic rsvd_mcast_lookup,
    output logic [9:0] table_index,
    output logic [2:0] entry_age_out,
    output logic entry_expired
);
    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [15:0] max_frame_length;
    logic [15:0] outer_tag_type;
    logic [7:0] lookup_engine_control_zero;
    logic [15:0] next_max_frame_length;
    logic [15:0] next_outer_tag_type;
    logic [7:0] next_lookup_engine_control_zero;
    logic [DATA_W-1:0] next_reg_rdata;
    logic truncated_count;
    logic [7:0] trunc_total;
    logic [7:0] next_trunc_total;
    logic frame_active;

    always_comb begin
        next_max_frame_length = max_frame_length;
        next_outer_tag_type = outer_tag_type;
        next_lookup_engine_control_zero = lookup_engine_control_zero;
        if (reg_write) begin
            unique case (reg_addr)
                OFS_MAX_FRAME_LENGTH:
                    next_max_frame_length = reg_wdata;
                OFS_OUTER_TAG_TYPE: next_outer_tag_type = reg_wdata;
                OFS_LOOKUP_CTRL_ZERO:
                    next_lookup_engine_control_zero = reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_reg_rdata = '0;
        if (reg_read) begin
            unique case (reg_addr)
                OFS_MAX_FRAME_LENGTH: next_reg_rdata = max_frame_length;
                OFS_OUTER_TAG_TYPE: next_reg_rdata = outer_tag_type;
                OFS_LOOKUP_CTRL_ZERO:
                    next_reg_rdata = {8'h00, lookup_engine_control_zero};
                OFS_FRAME_STATUS:
                    next_reg_rdata = {6'h00, frame_active, vlan_mode,
                                      trunc_total};
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            max_frame_length <= RST_MAX_FRAME_LENGTH;
            outer_tag_type <= RST_OUTER_TAG_TYPE;
            lookup_engine_control_zero <= RST_LOOKUP_CTRL_ZERO;
            reg_rdata <= '0;
        end else begin
            max_frame_length <= next_max_frame_length;
            outer_tag_type <= next_outer_tag_type;
            lookup_engine_control_zero <= next_lookup_engine_control_zero;
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-frame snapshot of settings
    logic next_frame_active;
    logic [13:0] snap_limit;
    logic [13:0] next_snap_limit;
    logic [15:0] snap_tag;
    logic [15:0] next_snap_tag;
    logic [7:0] snap_ctrl;
    logic [7:0] next_snap_ctrl;

    always_comb begin
        next_frame_active = frame_active;
        next_snap_limit = snap_limit;
        next_snap_tag = snap_tag;
        next_snap_ctrl = snap_ctrl;
        if (frame_start) begin
            next_frame_active = 1'b1;
            next_snap_limit = max_frame_length[MAX_LEN_W-1:0];
            next_snap_tag = outer_tag_type;
            next_snap_ctrl = lookup_engine_control_zero;
        end else if (!frame_valid) begin
            next_frame_active = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            frame_active <= 1'b0;
            snap_limit <= RST_MAX_FRAME_LENGTH[13:0];
            snap_tag <= RST_OUTER_TAG_TYPE;
            snap_ctrl <= RST_LOOKUP_CTRL_ZERO;
        end else begin
            frame_active <= next_frame_active;
            snap_limit <= next_snap_limit;
            snap_tag <= next_snap_tag;
            snap_ctrl <= next_snap_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decisions
    logic next_frame_truncate;
    logic [15:0] next_frame_tag_type;
    logic next_frame_drop;
    logic next_frame_to_host;
    logic vlan_on;

    assign vlan_on = snap_ctrl[BIT_VLAN_ENABLE];
    assign truncated_count = next_frame_truncate & ~frame_truncate;

    always_comb begin
        next_frame_truncate = frame_truncate;
        next_frame_drop = 1'b0;
        next_frame_to_host = 1'b0;
        next_frame_tag_type = snap_tag;
        if (frame_start) begin
            next_frame_truncate = 1'b0;
        end else if (frame_active && frame_valid) begin
            if (frame_byte_count > snap_limit) begin
                next_frame_truncate = 1'b1;
            end
            if (vlan_on && frame_vid_invalid) begin
                if (unknown_vid_fwd_en) begin
                    next_frame_to_host = unknown_vid_fwd_host;
                    next_frame_drop = 1'b0;
                end else if (snap_ctrl[BIT_INVALID_VLAN_DROP]) begin
                    next_frame_drop = 1'b1;
                end else begin
                    next_frame_to_host = 1'b1;
                end
            end
        end
        next_trunc_total = trunc_total + {7'h00, truncated_count};
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            frame_truncate <= 1'b0;
            frame_drop <= 1'b0;
            frame_to_host <= 1'b0;
            frame_tag_type <= RST_OUTER_TAG_TYPE;
            vlan_mode <= 1'b0;
            rsvd_mcast_lookup <= 1'b0;
            trunc_total <= 8'h00;
        end else begin
            frame_truncate <= next_frame_truncate;
            frame_drop <= next_frame_drop;
            frame_to_host <= next_frame_to_host;
            frame_tag_type <= next_frame_tag_type;
            vlan_mode <= vlan_on;
            rsvd_mcast_lookup <= snap_ctrl[BIT_RSVD_MCAST_EN];
            trunc_total <= next_trunc_total;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lookup index and aging
    logic [9:0] index_comb;
    logic [2:0] next_entry_age_out;
    logic next_entry_expired;

    slc_table_index u_index (
        .dest_addr(dest_addr),
        .method(lookup_engine_control_zero[1:0]),
        .index(index_comb)
    );

    always_comb begin
        next_entry_age_out = entry_age_in;
        next_entry_expired = 1'b0;
        if (entry_update) begin
            next_entry_age_out =
                lookup_engine_control_zero[AGE_LSB+2:AGE_LSB];
        end else if (age_tick) begin
            if (entry_age_in == 3'h0) begin
                next_entry_expired = 1'b1;
            end else begin
                next_entry_age_out = entry_age_in - 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            table_index <= 10'h000;
            entry_age_out <= RST_LOOKUP_CTRL_ZERO[AGE_LSB+2:AGE_LSB];
            entry_expired <= 1'b0;
        end else begin
            table_index <= index_comb;
            entry_age_out <= next_entry_age_out;
            entry_expired <= next_entry_expired;
        end
    end
endmodule

/* pkg/slc_pkg.sv */
package slc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    // Register byte offsets
    localparam logic [11:0] OFS_MAX_FRAME_LENGTH = 12'h308;
    localparam logic [11:0] OFS_OUTER_TAG_TYPE = 12'h30a;
    localparam logic [11:0] OFS_LOOKUP_CTRL_ZERO = 12'h310;
    localparam logic [11:0] OFS_FRAME_STATUS = 12'h320;
    // Reset values
    localparam logic [15:0] RST_MAX_FRAME_LENGTH = 16'h07d0;
    localparam logic [15:0] RST_OUTER_TAG_TYPE = 16'h9100;
    localparam logic [7:0] RST_LOOKUP_CTRL_ZERO = 8'h61;
    // Field positions in lookup control zero, then frame length width and jumbo limit
    localparam int BIT_VLAN_ENABLE = 7;
    localparam int BIT_INVALID_VLAN_DROP = 6;
    localparam int AGE_LSB = 3;
    localparam int BIT_RSVD_MCAST_EN = 2;
    localparam int MAX_LEN_W = 14;
    localparam logic [13:0] JUMBO_LIMIT = 14'h2328;
    // Index methods
    typedef enum logic [1:0] {
        SLC_IDX_DIRECT0 = 2'h0,
        SLC_IDX_CRC = 2'h1,
        SLC_IDX_XOR = 2'h2,
        SLC_IDX_DIRECT3 = 2'h3
    } slc_index_t;
    localparam int INDEX_W = 10;
endpackage

/* hw/slc_table_index.sv */
module slc_table_index
    import slc_pkg::*;
(
    input wire logic [47:0] dest_addr,
    input wire logic [1:0] method,
    output logic [9:0] index
);
    function automatic logic [9:0] crc_fold(input logic [47:0] a);
        logic [9:0] c;
        c = 10'h3ff;
        for (int i = 0; i < 48; i++) begin
            if (c[9] ^ a[i]) begin
                c = {c[8:0], 1'b0} ^ 10'h233;
            end else begin
                c = {c[8:0], 1'b0};
            end
        end
        return c;
    endfunction

    function automatic logic [9:0] xor_fold(input logic [47:0] a);
        logic [9:0] x;
        x = 10'h000;
        for (int i = 0; i < 48; i++) begin
            x[i % 10] = x[i % 10] ^ a[i];
        end
        return x;
    endfunction

    always_comb begin
        unique case (slc_index_t'(method))
            SLC_IDX_CRC: index = crc_fold(dest_addr);
            SLC_IDX_XOR: index = xor_fold(dest_addr);
            SLC_IDX_DIRECT0,
            SLC_IDX_DIRECT3: index = dest_addr[9:0];
        endcase
    end
endmodule

/* test/slc_global_config_props.sv */
module slc_global_config_props
    import slc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic frame_start,
    input wire logic frame_vid_invalid,
    input wire logic unknown_vid_fwd_en,
    input wire logic [47:0] dest_addr,
    input wire logic entry_update,
    input wire logic age_tick,
    input wire logic frame_truncate,
    input wire logic frame_drop,
    input wire logic [9:0] table_index,
    input wire logic [2:0] entry_age_out
);
    logic [15:0] max_sh, tag_sh;
    logic [7:0] ctrl_sh;
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of the writable registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            max_sh <= RST_MAX_FRAME_LENGTH;
            tag_sh <= RST_OUTER_TAG_TYPE;
            ctrl_sh <= RST_LOOKUP_CTRL_ZERO;
        end else if (reg_write) begin
            if (reg_addr == OFS_MAX_FRAME_LENGTH) max_sh <= reg_wdata;
            if (reg_addr == OFS_OUTER_TAG_TYPE) tag_sh <= reg_wdata;
            if (reg_addr == OFS_LOOKUP_CTRL_ZERO) ctrl_sh <= reg_wdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    AST_READ_MAX: assert property (
        reg_read && reg_addr == OFS_MAX_FRAME_LENGTH
        |=> reg_rdata == $past(max_sh))
        else $error("length readback wrong");
    AST_READ_TAG: assert property (
        reg_read && reg_addr == OFS_OUTER_TAG_TYPE
        |=> reg_rdata == $past(tag_sh))
        else $error("tag type readback wrong");
    AST_READ_CTRL: assert property (
        reg_read && reg_addr == OFS_LOOKUP_CTRL_ZERO
        |=> reg_rdata == {8'h00, $past(ctrl_sh)})
        else $error("lookup control readback wrong");
    AST_DIRECT_INDEX: assert property (
        (ctrl_sh[1:0] == 2'h0 || ctrl_sh[1:0] == 2'h3)
        |=> table_index == $past(dest_addr[9:0]))
        else $error("direct index wrong");
    AST_AGE_LOAD: assert property (
        entry_update && !age_tick
        |=> entry_age_out == $past(ctrl_sh[5:3]))
        else $error("age count not loaded");
    AST_TRUNC_STICKY: assert property (
        frame_truncate && !frame_start |=> frame_truncate)
        else $error("truncate flag dropped mid frame");
    AST_FWD_OVERRIDE: assert property (
        unknown_vid_fwd_en && frame_vid_invalid |=> !frame_drop)
        else $error("drop despite unknown vid forwarding");
endmodule

bind slc_global_config slc_global_config_props i_props (.core_clk, .reset,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .frame_start,
    .frame_vid_invalid, .unknown_vid_fwd_en, .dest_addr, .entry_update,
    .age_tick, .frame_truncate, .frame_drop, .table_index, .entry_age_out);

/* test/test_slc_global_config.sv */
module test_slc_global_config
    import slc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0;
    logic [11:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, frame_tag_type;
    logic frame_start = 0, frame_valid = 0, frame_has_tag = 0;
    logic frame_vid_invalid = 0, unknown_vid_fwd_en = 0;
    logic unknown_vid_fwd_host = 0, entry_update = 0, age_tick = 0;
    logic [13:0] frame_byte_count = 0;
    logic [47:0] dest_addr = 0;
    logic [2:0] entry_age_in = 0, entry_age_out;
    logic [9:0] table_index;
    logic frame_truncate, vlan_mode, frame_drop, frame_to_host;
    logic rsvd_mcast_lookup, entry_expired;
    int fails = 0, n_compared = 0, m_max = 16'h07d0, m_tag = 16'h9100;
    int m_ctrl = 16'h0061, c, lim;
    slc_global_config i_slc_global_config (.core_clk, .reset, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .frame_start,
        .frame_valid, .frame_byte_count, .frame_has_tag, .frame_vid_invalid,
        .unknown_vid_fwd_en, .unknown_vid_fwd_host, .dest_addr,
        .entry_update, .age_tick, .entry_age_in, .frame_truncate,
        .frame_tag_type, .vlan_mode, .frame_drop, .frame_to_host,
        .rsvd_mcast_lookup, .table_index, .entry_age_out, .entry_expired);
    always #10 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    // Bus, frame and compare tasks
    task automatic chk(input logic [15:0] got, input int exp);
        n_compared++;
        if (got !== 16'(exp)) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, 16'(exp));
        end
    endtask
    task automatic wr(input logic [11:0] a, input int d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= 16'(d);
        reg_write <= 1;
        @(posedge core_clk);
        reg_write <= 0;
        @(negedge core_clk);
        if (a == OFS_MAX_FRAME_LENGTH) m_max = d & 16'hffff;
        if (a == OFS_OUTER_TAG_TYPE) m_tag = d & 16'hffff;
        if (a == OFS_LOOKUP_CTRL_ZERO) m_ctrl = d & 16'h00ff;
    endtask
    task automatic rd(input logic [11:0] a, input int e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge core_clk);
        reg_read <= 0;
        @(negedge core_clk);
        chk(reg_rdata, e);
    endtask
    task automatic fr(input bit s, input int n);
        @(posedge core_clk);
        frame_start <= s;
        frame_valid <= 1;
        frame_byte_count <= 14'(n);
        @(posedge core_clk);
        frame_start <= 0;
        @(negedge core_clk);
    endtask
    task automatic fend;
        @(posedge core_clk);
        frame_valid <= 0;
    endtask
    task automatic final_report;
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h821eddec));
        repeat (3) @(posedge core_clk);
        reset <= 0;
        rd(OFS_MAX_FRAME_LENGTH, m_max);
        rd(OFS_OUTER_TAG_TYPE, m_tag);
        rd(OFS_LOOKUP_CTRL_ZERO, m_ctrl);
        wr(12'h400, 16'hffff);
        rd(12'h400, 0);
        wr(OFS_OUTER_TAG_TYPE, $urandom);
        rd(OFS_OUTER_TAG_TYPE, m_tag);
        for (int k = 0; k < 2; k++) begin
            lim = k ? 50 + $urandom % 100 : 16'h2328;
            wr(OFS_MAX_FRAME_LENGTH, 16'hc000 | lim);
            rd(OFS_MAX_FRAME_LENGTH, m_max);
            fr(1, 0);
            wr(OFS_MAX_FRAME_LENGTH, 1);
            fr(0, lim);
            chk(frame_truncate, 0);
            fr(0, lim + 1);
            chk(frame_truncate, 1);
            fend();
            fr(1, 0);
            chk(frame_truncate, 0);
            fr(0, 2);
            chk(frame_truncate, 1);
            fend();
        end
        frame_vid_invalid <= 1;
        for (int i = 0; i < 16; i++) begin
            c = {i[3], i[2], 3'(i), i[1], 2'(i)};
            wr(OFS_LOOKUP_CTRL_ZERO, c);
            rd(OFS_LOOKUP_CTRL_ZERO, m_ctrl);
            @(posedge core_clk);
            unknown_vid_fwd_en <= i[0];
            unknown_vid_fwd_host <= i[1];
            dest_addr <= {16'($urandom), $urandom};
            entry_update <= 1;
            entry_age_in <= 3'($urandom);
            @(posedge core_clk);
            entry_update <= 0;
            @(negedge core_clk);
            chk(entry_age_out, c[5:3]);
            fr(1, 0);
            fr(0, 1);
            chk(frame_drop, c[7] && c[6] && !i[0]);
            chk(frame_to_host, c[7] && (i[0] ? i[1] : !c[6]));
            chk(vlan_mode, c[7]);
            chk(rsvd_mcast_lookup, c[2]);
            chk(frame_tag_type, m_tag);
            if (i[1:0] == 0 || i[1:0] == 3) begin
                chk(table_index, dest_addr[9:0]);
            end
            fend();
            age_tick <= 1;
            @(posedge core_clk);
            age_tick <= 0;
            @(negedge core_clk);
            chk(entry_expired, entry_age_in == 0);
            chk(entry_age_out, entry_age_in == 0 ? 0 : entry_age_in - 1);
        end
        final_report();
    end
    initial begin
        #(20 * 20000);
        fails++;
        final_report();
    end
endmodule
